/* File: hw/squib_cmd_port.sv */
`timescale 1ns/10ps

// Behaviour
// - Select rising edge latches shifted command word
// - Select falling edge loads pending result
// - Input bit sampled on serial clock rise
// - Output bit changes on serial clock fall
// - Reset low clears functions and shift registers
// - Pair A drivers only with enable A
// - Pair B drivers only with enable B
// - Diagnostics work regardless of fire enables
// - Fire reaches drivers well within 72 us
// - Turn-off reaches drivers well within 10 us
// - Resistance result valid within 300 us
// - Open/short result valid within 3000 us
// - Supply check result valid within 3000 us
// - Safing sensor result valid within 1000 us
// - Transistor test result valid within 1000 us
// - Fire return result valid within 300 us
// - Low-side continuity valid within 3000 us
// - Loop short result valid within 3000 us
// - Sense inputs feed diagnostics only, never firing
// - Exact 8-bit MSB-first frames accepted; a clockless frame after one repeats its word
// - Reply is previous result; NOP clears diagnostics
// - Output released while select is high
// - Clock level at select fall picks framing
module squib_cmd_port
	import squib_port_pkg::*;
#(
	parameter int FAST_CYC = T_DIAG_FAST_US * CLK_MHZ,
	parameter int MID_CYC  = T_DIAG_MID_US * CLK_MHZ,
	parameter int SLOW_CYC = T_DIAG_SLOW_US * CLK_MHZ
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       serial_clk_i,
	input  wire logic       select_n_i,
	input  wire logic       serial_in_pin_i,
	output logic            serial_out_pin_o,
	output logic            serial_out_pin_oe_o,
	input  wire logic       device_reset_n_i,
	input  wire logic       fire_enable_pair_a_i,
	input  wire logic       fire_enable_pair_b_i,
	input  wire logic [3:0] channel_sense_input_i,
	input  wire logic       fire_return_open_i,
	input  wire logic [7:0] meas_value_i,
	input  wire logic       meas_done_i,
	output logic            diag_start_o,
	output logic [7:0]      diag_cmd_o,
	output logic            diag_busy_o,
	output logic            framing_alt_o,
	output logic [3:0]      high_side_on_o,
	output logic [3:0]      low_side_on_o
);

	// Link domain, clocked by the host serial clock
	logic [7:0]       rx_shift_r;
	logic [CNT_W-1:0] bit_cnt_r;
	logic             in_frame_r;
	logic             out_bit_r;
	logic             out_seen_r;
	logic             frame_rst_n;
	logic [3:0]       out_idx;

	// System domain
	localparam int SYNC_W = 10;
	logic [SYNC_W-1:0] sync1_r;
	logic [SYNC_W-1:0] sync2_r;
	logic              sel_prev_r;
	logic              sel_s;
	logic              sclk_s;
	logic              rstn_s;
	logic              fen_a_s;
	logic              fen_b_s;
	logic              ret_s;
	logic [3:0]        sense_s;
	logic              srst;
	logic              sel_rise;
	logic              sel_fall;
	logic              word_ok;
	logic [7:0]        tx_word_r;
	logic [7:0]        result_r;
	logic [7:0]        result_nxt;
	logic [3:0]        fire_mask_r;
	logic [1:0]        fen_ok;
	logic [7:0]        cmd_r;
	diag_class_type    cls;
	diag_state_type    state_r;
	logic [TMR_W-1:0]  timer_r;
	logic [TMR_W-1:0]  limit_r;
	logic              meas_end;

	function automatic diag_class_type classify(input logic [7:0] c);
		diag_class_type k;
		k = CLS_NONE;
		if (c == CMD_ECHO)
			k = CLS_ECHO;
		else if (c[7:4] == GRP_RESIST && c[3:2] == GRP_SUB_LOW)
			k = CLS_FAST;
		else if (c == CMD_RETURN)
			k = CLS_FAST;
		else if (c == CMD_SAFING || c == CMD_FET_LO || c == CMD_FET_HI)
			k = CLS_MID;
		else if (c == CMD_RESISTOR)
			k = CLS_MID;
		else if (c == CMD_SHORT_BAT || c == CMD_SHORT_OPEN || c == CMD_SUPPLY)
			k = CLS_SLOW;
		else if (c == CMD_LO_CONT || c == CMD_LOOP_SENSE || c == CMD_E_SENSE)
			k = CLS_SLOW;
		else if (c[7:4] == GRP_LOOP && c[3:2] == GRP_SUB_LOW)
			k = CLS_SLOW;
		else if (c[7:4] == GRP_F && c[3:2] == GRP_SUB_LOW)
			k = CLS_SLOW;
		return k;
	endfunction

	function automatic logic uses_sense(input logic [7:0] c);
		logic s;
		s = 1'b0;
		if (c == CMD_SHORT_BAT || c == CMD_LO_CONT || c == CMD_SHORT_OPEN)
			s = 1'b1;
		if (c == CMD_RETURN || c == CMD_E_SENSE || c == CMD_FET_LO || c == CMD_FET_HI)
			s = 1'b1;
		if ((c[7:4] == GRP_RESIST || c[7:4] == GRP_F) && c[3:2] == GRP_SUB_LOW)
			s = 1'b1;
		return s;
	endfunction

	// ---------------- Link domain ----------------

	// Frame state forgets itself whenever the host deselects
	assign frame_rst_n = device_reset_n_i & ~select_n_i;

	always_ff @(posedge serial_clk_i or negedge device_reset_n_i) begin
		if (!device_reset_n_i) begin
			rx_shift_r <= RESULT_RST;
		end else if (!select_n_i) begin
			rx_shift_r <= {rx_shift_r[6:0], serial_in_pin_i};
		end
	end

	// Count kept past the frame so the system side can judge length
	always_ff @(posedge serial_clk_i or negedge device_reset_n_i) begin
		if (!device_reset_n_i) begin
			bit_cnt_r <= '0;
		end else if (!select_n_i) begin
			if (!in_frame_r)
				bit_cnt_r <= CNT_W'(1);
			else if (bit_cnt_r != CNT_MAX)
				bit_cnt_r <= bit_cnt_r + CNT_W'(1);
		end
	end

	always_ff @(posedge serial_clk_i or negedge frame_rst_n) begin
		if (!frame_rst_n)
			in_frame_r <= 1'b0;
		else
			in_frame_r <= 1'b1;
	end

	assign out_idx = in_frame_r ? bit_cnt_r : 4'h0;

	// A fall before any rise (clock high at select) still shows the MSB
	always_ff @(negedge serial_clk_i or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			out_bit_r  <= 1'b0;
			out_seen_r <= 1'b0;
		end else begin
			out_seen_r <= 1'b1;
			if (out_idx < CNT_WORD)
				out_bit_r <= tx_word_r[3'(7 - out_idx)];
			else
				out_bit_r <= 1'b0;
		end
	end

	// MSB is visible from select fall, before the first clock edge
	assign serial_out_pin_o    = out_seen_r ? out_bit_r : tx_word_r[7];
	assign serial_out_pin_oe_o = ~select_n_i;

	// ---------------- System domain ----------------

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= {select_n_i, serial_clk_i, device_reset_n_i,
				fire_enable_pair_b_i, fire_enable_pair_a_i,
				fire_return_open_i, channel_sense_input_i};
			sync2_r <= sync1_r;
		end
	end

	assign sel_s   = sync2_r[9];
	assign sclk_s  = sync2_r[8];
	assign rstn_s  = sync2_r[7];
	assign fen_b_s = sync2_r[6];
	assign fen_a_s = sync2_r[5];
	assign ret_s   = sync2_r[4];
	assign sense_s = sync2_r[3:0];

	assign srst = rst_i | ~rstn_s;

	always_ff @(posedge clk_i) begin
		if (srst)
			sel_prev_r <= 1'b1;
		else
			sel_prev_r <= sel_s;
	end

	assign sel_rise = sel_s & ~sel_prev_r;
	assign sel_fall = ~sel_s & sel_prev_r;

	// Link words are still while select is high, so sampling is safe
	assign word_ok = sel_rise & (bit_cnt_r == CNT_WORD);

	always_ff @(posedge clk_i) begin
		if (srst)
			framing_alt_o <= 1'b0;
		else if (sel_fall)
			framing_alt_o <= sclk_s;
	end

	// Reply frozen from select fall; the link reads it as a static word.
	// The few cycles of sync lag are covered by a result that never
	// changes once complete.
	always_ff @(posedge clk_i) begin
		if (srst)
			tx_word_r <= RESULT_RST;
		else if (sel_s)
			tx_word_r <= result_r;
	end

	always_ff @(posedge clk_i) begin
		if (srst)
			cmd_r <= CMD_NOP;
		else if (word_ok)
			cmd_r <= rx_shift_r;
	end

	always_comb begin
		cls = classify(rx_shift_r);
	end

	// Fire mask, a zero mask is the turn-off command
	always_ff @(posedge clk_i) begin
		if (srst)
			fire_mask_r <= FIRE_RST;
		else if (word_ok && rx_shift_r[7:4] == GRP_FIRE)
			fire_mask_r <= rx_shift_r[3:0];
	end

	// Enable must stay high for the filter time to arm a pair
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_fen
			logic [FEN_W-1:0] stab_r;
			logic             level_r;
			logic             raw;
			assign raw = (g == 0) ? fen_a_s : fen_b_s;
			always_ff @(posedge clk_i) begin
				if (srst) begin
					stab_r  <= '0;
					level_r <= 1'b0;
				end else if (raw == level_r) begin
					stab_r <= '0;
				end else if (!raw) begin
					// Disarm at once, a low enable must stop the drivers
					stab_r  <= '0;
					level_r <= 1'b0;
				end else if (stab_r == FEN_W'(FEN_FILTER_CYC - 1)) begin
					stab_r  <= '0;
					level_r <= raw;
				end else begin
					stab_r <= stab_r + FEN_W'(1);
				end
			end
			assign fen_ok[g] = level_r;
		end
	endgenerate

	// Two cycles from latch to driver, far inside the on and off limits
	always_ff @(posedge clk_i) begin
		if (srst) begin
			high_side_on_o <= FIRE_RST;
			low_side_on_o  <= FIRE_RST;
		end else begin
			high_side_on_o[1:0] <= fire_mask_r[1:0] & {2{fen_ok[0]}};
			low_side_on_o[1:0]  <= fire_mask_r[1:0] & {2{fen_ok[0]}};
			high_side_on_o[3:2] <= fire_mask_r[3:2] & {2{fen_ok[1]}};
			low_side_on_o[3:2]  <= fire_mask_r[3:2] & {2{fen_ok[1]}};
		end
	end

	// Result word, sense only reaches it here
	always_comb begin
		result_nxt = meas_value_i;
		if (cmd_r == CMD_RETURN)
			result_nxt = {meas_value_i[7:5], ret_s, sense_s};
		else if (cmd_r == CMD_RESISTOR)
			result_nxt = {1'b0, meas_value_i[6:0]};
		else if (uses_sense(cmd_r))
			result_nxt = {meas_value_i[7:4], sense_s};
	end

	// Deadline forces capture even if the front end stays silent
	assign meas_end = meas_done_i | (timer_r == limit_r);

	always_ff @(posedge clk_i) begin
		if (srst) begin
			state_r <= ST_IDLE;
			timer_r <= '0;
			limit_r <= '0;
		end else if (word_ok) begin
			timer_r <= '0;
			state_r <= ST_IDLE;
			case (cls)
				CLS_FAST: begin
					state_r <= ST_MEASURE;
					limit_r <= TMR_W'(FAST_CYC - 1);
				end
				CLS_MID: begin
					state_r <= ST_MEASURE;
					limit_r <= TMR_W'(MID_CYC - 1);
				end
				CLS_SLOW: begin
					state_r <= ST_MEASURE;
					limit_r <= TMR_W'(SLOW_CYC - 1);
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end else begin
			case (state_r)
				ST_IDLE: begin
					timer_r <= '0;
				end
				ST_MEASURE: begin
					if (meas_end)
						state_r <= ST_IDLE;
					else
						timer_r <= timer_r + TMR_W'(1);
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// Any accepted word drops the old result; no fire enable involved
	always_ff @(posedge clk_i) begin
		if (srst)
			result_r <= RESULT_RST;
		else if (word_ok && cls == CLS_ECHO)
			result_r <= ECHO_REPLY;
		else if (word_ok)
			result_r <= RESULT_RST;
		else if (state_r == ST_MEASURE && meas_end)
			result_r <= result_nxt;
	end

	always_ff @(posedge clk_i) begin
		if (srst) begin
			diag_start_o <= 1'b0;
			diag_cmd_o   <= CMD_NOP;
		end else begin
			diag_start_o <= word_ok && cls != CLS_NONE && cls != CLS_ECHO;
			if (word_ok)
				diag_cmd_o <= rx_shift_r;
		end
	end

	// Host spacing lets a measurement start before the next frame ends
	assign diag_busy_o = (state_r == ST_MEASURE);

endmodule // squib_cmd_port

/* File: hw/squib_port_pkg.sv */
package squib_port_pkg;

	// Word framing
	localparam int          WORD_BITS  = 8;
	localparam int          CNT_W      = 4;
	localparam logic [3:0]  CNT_WORD   = 4'h8;
	localparam logic [3:0]  CNT_MAX    = 4'hF;

	// System clock rate
	localparam int          CLK_MHZ    = 50;

	// Result valid deadlines, microseconds
	localparam int          T_DIAG_FAST_US = 300;
	localparam int          T_DIAG_MID_US  = 1000;
	localparam int          T_DIAG_SLOW_US = 3000;
	localparam int          TMR_W          = 18;

	// Least pulse width accepted on a fire enable, microseconds
	localparam int          T_FEN_FILTER_US = 12;
	localparam int          FEN_FILTER_CYC  = T_FEN_FILTER_US * CLK_MHZ;
	localparam int          FEN_W           = 10;

	// Command codes
	localparam logic [7:0]  CMD_NOP        = 8'h00;
	localparam logic [7:0]  CMD_ECHO       = 8'h96;
	localparam logic [7:0]  ECHO_REPLY     = 8'h69;
	localparam logic [7:0]  CMD_SAFING     = 8'hC0;
	localparam logic [7:0]  CMD_SHORT_BAT  = 8'hC1;
	localparam logic [7:0]  CMD_LO_CONT    = 8'hC2;
	localparam logic [7:0]  CMD_SHORT_OPEN = 8'hC3;
	localparam logic [7:0]  CMD_SUPPLY     = 8'hC5;
	localparam logic [7:0]  CMD_RESISTOR   = 8'hC8;
	localparam logic [7:0]  CMD_RETURN     = 8'hC9;
	localparam logic [7:0]  CMD_LOOP_SENSE = 8'hE8;
	localparam logic [7:0]  CMD_E_SENSE    = 8'hE9;
	localparam logic [7:0]  CMD_FET_LO     = 8'h82;
	localparam logic [7:0]  CMD_FET_HI     = 8'h83;
	localparam logic [3:0]  GRP_RESIST     = 4'hD;
	localparam logic [3:0]  GRP_LOOP       = 4'hE;
	localparam logic [3:0]  GRP_F          = 4'hF;
	localparam logic [3:0]  GRP_FIRE       = 4'hA;
	localparam logic [1:0]  GRP_SUB_LOW    = 2'h0;

	// Reset values
	localparam logic [7:0]  RESULT_RST     = 8'h00;
	localparam logic [3:0]  FIRE_RST       = 4'h0;

	typedef enum logic [2:0] {
		CLS_NONE,
		CLS_ECHO,
		CLS_FAST,
		CLS_MID,
		CLS_SLOW
	} diag_class_type;

	typedef enum logic {
		ST_IDLE,
		ST_MEASURE
	} diag_state_type;

endpackage

/* File: tb/squib_host.sv */
`timescale 1ns/10ps

module squib_host (
	output logic      serial_clk_o,
	output logic      select_n_o,
	output logic      mosi_o,
	input  wire logic miso_i
);
	initial begin
		serial_clk_o = 1'b0;
		select_n_o = 1'b1;
		mosi_o = 1'b0;
	end

	task automatic xfer(input logic [7:0] tx, input int nb, input logic alt,
		output logic [7:0] rx);
		int i;
		rx = 8'h00;
		serial_clk_o = alt;
		#40;
		select_n_o = 1'b0;
		#62;
		for (i = 0; i < nb; i++) begin
			serial_clk_o = 1'b0;
			mosi_o = tx[7 - (i % 8)];
			#62;
			rx = {rx[6:0], miso_i};
			serial_clk_o = 1'b1;
			#63;
		end
		serial_clk_o = 1'b0;
		#62;
		select_n_o = 1'b1;
		// Released input falls to its pull-down level
		mosi_o = 1'b0;
		#2600;
	endtask
endmodule // squib_host

/* File: tb/squib_cmd_port_chk.sv */
`timescale 1ns/10ps

module squib_cmd_port_chk
	import squib_port_pkg::*;
#(
	parameter int FAST_CYC = 20,
	parameter int MID_CYC  = 40,
	parameter int SLOW_CYC = 60
) (
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       select_n_i,
	input wire logic       device_reset_n_i,
	input wire logic       fire_enable_pair_a_i,
	input wire logic       fire_enable_pair_b_i,
	input wire logic       serial_out_pin_oe_o,
	input wire logic       diag_start_o,
	input wire logic [7:0] diag_cmd_o,
	input wire logic       diag_busy_o,
	input wire logic [3:0] high_side_on_o,
	input wire logic [3:0] low_side_on_o
);
	localparam int BUSY_LIM = SLOW_CYC + 4;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	oe_release_a: assert property (serial_out_pin_oe_o == !select_n_i)
		else $error("output enable does not follow select");
	dev_reset_a: assert property (!device_reset_n_i [*5] |->
		diag_cmd_o == 8'h00 && high_side_on_o == 4'h0 && !diag_busy_o)
		else $error("device reset did not clear state");
	latch_deselect_a: assert property ($changed(diag_cmd_o) && device_reset_n_i |->
		select_n_i && $past(select_n_i, 2))
		else $error("command changed while selected");
	pair_a_off_a: assert property (!fire_enable_pair_a_i [*5] |->
		high_side_on_o[1:0] == 2'h0 && low_side_on_o[1:0] == 2'h0)
		else $error("pair a driven without enable");
	pair_b_off_a: assert property (!fire_enable_pair_b_i [*5] |->
		high_side_on_o[3:2] == 2'h0 && low_side_on_o[3:2] == 2'h0)
		else $error("pair b driven without enable");
	busy_bound_a: assert property ($rose(diag_busy_o) |-> ##[1:BUSY_LIM] !diag_busy_o)
		else $error("measurement exceeded deadline");
	start_pulse_a: assert property (diag_start_o |=> !diag_start_o && diag_busy_o)
		else $error("start pulse malformed");
	nop_clear_a: assert property (diag_cmd_o == CMD_NOP [*3] |-> !diag_busy_o)
		else $error("no-operation left a measurement pending");
endmodule // squib_cmd_port_chk

bind squib_cmd_port squib_cmd_port_chk #(.FAST_CYC(FAST_CYC), .MID_CYC(MID_CYC),
	.SLOW_CYC(SLOW_CYC)) chk_i (.clk_i, .rst_i, .select_n_i, .device_reset_n_i,
	.fire_enable_pair_a_i, .fire_enable_pair_b_i, .serial_out_pin_oe_o, .diag_start_o,
	.diag_cmd_o, .diag_busy_o, .high_side_on_o, .low_side_on_o);

/* File: tb/squib_cmd_port_tb.sv */
`timescale 1ns/10ps

module squib_cmd_port_tb;
	import squib_port_pkg::*;
	logic       clk_i = 1'b0, rst_i = 1'b1, dev_rst_n = 1'b0, fen_a = 1'b0, fen_b = 1'b0;
	logic       ret_open = 1'b1, alt_o, busy, done = 1'b0;
	logic [3:0] sense = 4'h6, hs, ls;
	logic [7:0] meas = 8'hC7, rx, dcmd;
	wire        sclk, sel_n, mosi, sout, soe, miso;
	int         n_errors = 0, n_tests = 0;

	always #10 clk_i = ~clk_i;
	// Released line shows the inverse, so a late sample cannot pass
	assign miso = soe ? sout : ~sout;

	squib_host host (.serial_clk_o(sclk), .select_n_o(sel_n), .mosi_o(mosi), .miso_i(miso));

	squib_cmd_port #(.FAST_CYC(20), .MID_CYC(40), .SLOW_CYC(60)) DUT (
		.clk_i(clk_i), .rst_i(rst_i), .serial_clk_i(sclk), .select_n_i(sel_n),
		.serial_in_pin_i(mosi), .serial_out_pin_o(sout), .serial_out_pin_oe_o(soe),
		.device_reset_n_i(dev_rst_n), .fire_enable_pair_a_i(fen_a),
		.fire_enable_pair_b_i(fen_b), .channel_sense_input_i(sense),
		.fire_return_open_i(ret_open), .meas_value_i(meas), .meas_done_i(done),
		.diag_start_o(), .diag_cmd_o(dcmd), .diag_busy_o(busy), .framing_alt_o(alt_o),
		.high_side_on_o(hs), .low_side_on_o(ls));

	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// Realign to the system clock so bench inputs never move on an edge
	task automatic xf(input logic [7:0] tx, input int nb, input logic alt);
		host.xfer(tx, nb, alt, rx);
		idle(1);
	endtask

	task automatic t_echo;
		xf(CMD_ECHO, 8, 1'b0);
		chk("cmd", CMD_ECHO, dcmd);
		xf(CMD_NOP, 8, 1'b0);
		chk("echo", ECHO_REPLY, rx);
	endtask

	task automatic t_len;
		xf(CMD_ECHO, 7, 1'b0);
		chk("short_frame", CMD_NOP, dcmd);
		xf(CMD_ECHO, 9, 1'b0);
		chk("long_frame", CMD_NOP, dcmd);
		xf(CMD_NOP, 8, 1'b0);
		chk("no_echo", 8'h00, rx);
	endtask

	task automatic t_diag;
		logic [7:0] codes [5] = '{8'hD0, CMD_RETURN, CMD_SAFING, CMD_RESISTOR, CMD_SUPPLY};
		logic [7:0] exp;
		int i;
		for (i = 0; i < 5; i++) begin
			case (codes[i])
				CMD_RESISTOR: exp = {1'b0, meas[6:0]};
				CMD_RETURN: exp = {meas[7:5], ret_open, sense};
				default: exp = (codes[i][7:4] == GRP_RESIST) ? {meas[7:4], sense} : meas;
			endcase
			xf(codes[i], 8, i == 4);
			chk("framing", {7'h0, i == 4}, {7'h0, alt_o});
			chk("busy", 8'h00, {7'h0, busy});
			// Front-end value moves; the captured result must not
			meas = ~meas;
			xf(CMD_NOP, 8, 1'b0);
			chk("result", exp, rx);
			meas = ~meas;
		end
	endtask

	// Front end reports early; its value must win over the deadline capture
	task automatic t_done;
		int         k;
		logic [7:0] keep;
		keep = meas;
		fork
			xf(CMD_SUPPLY, 8, 1'b0);
			begin
				for (k = 0; k < 400 && !busy; k++) @(posedge clk_i);
				if (k == 400) begin
					n_errors++;
					wrap_up;
				end
				#1;
				meas = 8'h3C;
				done = 1'b1;
				@(posedge clk_i);
				#1;
				done = 1'b0;
				meas = keep;
			end
		join
		chk("done_busy", 8'h00, {7'h0, busy});
		xf(CMD_NOP, 8, 1'b0);
		chk("done_result", 8'h3C, rx);
	endtask

	task automatic t_fire;
		fen_b = 1'b1;
		idle(700);
		xf({GRP_FIRE, 4'h5}, 8, 1'b0);
		chk("hs_b_only", 8'h04, {4'h0, hs});
		chk("ls_b_only", 8'h04, {4'h0, ls});
		fen_a = 1'b1;
		idle(700);
		xf({GRP_FIRE, 4'h5}, 8, 1'b0);
		chk("hs_both", 8'h05, {4'h0, hs});
		fen_a = 1'b0;
		idle(6);
		chk("hs_a_drop", 8'h04, {4'h0, hs});
		chk("ls_a_drop", 8'h04, {4'h0, ls});
		xf({GRP_FIRE, 4'h0}, 8, 1'b0);
		chk("hs_off", 8'h00, {4'h0, hs});
		fen_a = 1'b0;
		fen_b = 1'b0;
	endtask

	task automatic t_reset;
		xf(CMD_ECHO, 8, 1'b0);
		dev_rst_n = 1'b0;
		idle(6);
		chk("rst_cmd", 8'h00, dcmd);
		dev_rst_n = 1'b1;
		idle(6);
		xf(CMD_NOP, 8, 1'b0);
		chk("rst_reply", 8'h00, rx);
	endtask

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	initial begin
		idle(3);
		rst_i = 1'b0;
		dev_rst_n = 1'b1;
		idle(6);
		t_echo;
		t_len;
		t_diag;
		t_done;
		t_fire;
		t_reset;
		wrap_up;
	end

	initial begin
		#1000000;
		n_errors++;
		wrap_up;
	end
endmodule // squib_cmd_port_tb
